// ---- core/spi_nv_pkg.sv ----
// Constants for the serial nonvolatile memory front end.
// Assumes one system clock of 250 MHz that samples all pins.
package spi_nv_pkg;
	localparam int ADDR_W       = 13;
	localparam int DATA_W       = 8;
	localparam int MEM_BYTES    = 8192;
	localparam int PAGE_BYTES   = 32;
	localparam int PAGE_BITS    = 5;
	localparam int CLK_MHZ      = 250;
	localparam int PROG_TIME_MS = 5;
	localparam int PROG_CYCLES  = PROG_TIME_MS * CLK_MHZ * 1000;
	// Opcode low nibble, upper nibble zero, bit 3 ignored
	localparam logic [7:0] OPC_MASK       = 8'hF7;
	localparam logic [7:0] OPC_SET_LATCH  = 8'h06;
	localparam logic [7:0] OPC_CLR_LATCH  = 8'h04;
	localparam logic [7:0] OPC_READ_STATE = 8'h05;
	localparam logic [7:0] OPC_WRITE_STATE = 8'h01;
	localparam logic [7:0] OPC_READ       = 8'h03;
	localparam logic [7:0] OPC_WRITE      = 8'h02;
	// State byte fields
	localparam int ST_GUARD_EN = 7;
	localparam int ST_BG_HI    = 3;
	localparam int ST_BG_LO    = 2;
	localparam int ST_LATCH    = 1;
	localparam int ST_BUSY     = 0;
	localparam logic [7:0] ST_BUSY_VALUE = 8'hFF;
	// Protected region starts per guard level
	localparam logic [12:0] GUARD_Q_BASE = 13'h1800;
	localparam logic [12:0] GUARD_H_BASE = 13'h1000;
	// Nonvolatile guard bits after reset (stands in for erased cells)
	localparam logic GUARD_RESET = 1'b0;
endpackage

// ---- core/nv_byte_mem.sv ----
// Byte array with registered read data.
// Assumes single clock; write and read may occur in the same cycle.
`timescale 1ns/1ps
module nv_byte_mem #(
	parameter int DEPTH  = 8192,
	parameter int AW     = 13
) (
	// Clock
	input  wire logic          clk,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	// Read port
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);
	logic [7:0] mem [DEPTH];

	initial
	begin
		if (DEPTH != (1 << AW))
			$error("nv_byte_mem: DEPTH must equal 2**AW");
	end

	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge clk)
	begin
		rdata <= mem[raddr];
	end
endmodule

// ---- core/spi_nv_core.sv ----
// Serial-bus front end of a byte-wide nonvolatile memory with protection.
// Assumes a mode 0/3 master; all pins are asynchronous to clk.
`timescale 1ns/1ps
module spi_nv_core #(
	parameter int PROG_CYCLES = spi_nv_pkg::PROG_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Serial pins
	input  wire logic sel_n,
	input  wire logic sck,
	input  wire logic sdi,
	output logic      sdo,
	output logic      sdo_oe,
	input  wire logic pause_n,
	input  wire logic guard_pin_n
);
	localparam int AW = spi_nv_pkg::ADDR_W;

	initial
	begin
		if (PROG_CYCLES < 1)
			$error("spi_nv_core: PROG_CYCLES must be at least 1");
	end

	typedef enum logic [2:0] {OP_IDLE, OP_ADDR, OP_READ, OP_WDATA, OP_WSTATE,
		OP_RSTATE, OP_IGNORE} phase_t;

	// Pin synchronisers
	logic [1:0] sel_s, sck_s, sdi_s, pause_s, guard_s;
	always_ff @(posedge clk)
	begin
		sel_s   <= {sel_s[0], sel_n};
		sck_s   <= {sck_s[0], sck};
		sdi_s   <= {sdi_s[0], sdi};
		pause_s <= {pause_s[0], pause_n};
		guard_s <= {guard_s[0], guard_pin_n};
	end

	logic sck_d_r, sel_d_r;
	always_ff @(posedge clk)
	begin
		sck_d_r <= sck_s[1];
		sel_d_r <= sel_s[1];
	end

	logic selected, rise, fall, sel_fall, sel_rise, paused_r;
	assign selected = !sel_s[1];
	assign rise     = selected && !paused_r && sck_s[1] && !sck_d_r;
	assign fall     = selected && !paused_r && !sck_s[1] && sck_d_r;
	assign sel_fall = sel_d_r && !sel_s[1];
	assign sel_rise = !sel_d_r && sel_s[1];

	// Pause only changes while clock is low; clock activity is masked meanwhile
	always_ff @(posedge clk)
	begin
		if (reset || !selected)
			paused_r <= 1'b0;
		else if (!sck_s[1])
			paused_r <= !pause_s[1];
	end

	// Mode 3 idles high, so the first falling edge after select carries no data
	phase_t      phase_r;
	logic [7:0]  shift_r;
	logic [2:0]  bitcnt_r;
	logic [4:0]  bytecnt_r;
	logic [7:0]  opcode_r;
	logic [AW-1:0] addr_r;
	logic        byte_done;
	logic [7:0]  byte_in;
	assign byte_in   = {shift_r[6:0], sdi_s[1]};
	assign byte_done = rise && (bitcnt_r == 3'd7);

	logic       busy_r, latch_r, guard_en_r, bg_hi_r, bg_lo_r;
	logic       hw_guard, blk_prot;
	logic [7:0] state_byte;
	logic [7:0] opc_m;
	assign opc_m    = byte_in & spi_nv_pkg::OPC_MASK;
	assign hw_guard = guard_en_r && !guard_s[1];

	// Write staging: page image plus a touched mask
	logic [7:0]  page_r [spi_nv_pkg::PAGE_BYTES];
	logic [spi_nv_pkg::PAGE_BYTES-1:0] touched_r;
	logic        wr_armed_r, st_armed_r;
	logic [7:0]  st_new_r;

	always_comb
	begin
		case ({bg_hi_r, bg_lo_r})
			2'b01:   blk_prot = addr_r >= spi_nv_pkg::GUARD_Q_BASE;
			2'b10:   blk_prot = addr_r >= spi_nv_pkg::GUARD_H_BASE;
			2'b11:   blk_prot = 1'b1;
			default: blk_prot = 1'b0;
		endcase
	end

	always_comb
	begin
		if (busy_r)
			state_byte = spi_nv_pkg::ST_BUSY_VALUE;
		else
		begin
			state_byte = 8'h00;
			state_byte[spi_nv_pkg::ST_GUARD_EN] = guard_en_r;
			state_byte[spi_nv_pkg::ST_BG_HI]    = bg_hi_r;
			state_byte[spi_nv_pkg::ST_BG_LO]    = bg_lo_r;
			state_byte[spi_nv_pkg::ST_LATCH]    = latch_r;
			state_byte[spi_nv_pkg::ST_BUSY]     = 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge clk)
	begin
		if (reset || !selected)
		begin
			phase_r   <= OP_IDLE;
			bitcnt_r  <= 3'd0;
			bytecnt_r <= 5'd0;
			shift_r   <= 8'h00;
		end
		else if (rise)
		begin
			shift_r  <= byte_in;
			bitcnt_r <= bitcnt_r + 3'd1;
			if (byte_done)
			begin
				case (phase_r)
					OP_IDLE:
					begin
						opcode_r  <= opc_m;
						bytecnt_r <= 5'd0;
						if (opc_m == spi_nv_pkg::OPC_READ_STATE)
							phase_r <= OP_RSTATE;
						else if (busy_r)
							phase_r <= OP_IGNORE;
						else if (opc_m == spi_nv_pkg::OPC_READ ||
							opc_m == spi_nv_pkg::OPC_WRITE)
							phase_r <= OP_ADDR;
						else if (opc_m == spi_nv_pkg::OPC_WRITE_STATE)
							phase_r <= OP_WSTATE;
						else
							phase_r <= OP_IGNORE;
					end
					OP_ADDR:
					begin
						bytecnt_r <= bytecnt_r + 5'd1;
						if (bytecnt_r == 5'd0)
							addr_r[AW-1:8] <= byte_in[AW-9:0];
						else
						begin
							addr_r[7:0] <= byte_in;
							bytecnt_r   <= 5'd0;
							phase_r     <= (opcode_r == spi_nv_pkg::OPC_READ) ? OP_READ
								: (latch_r ? OP_WDATA : OP_IGNORE);
						end
					end
					OP_READ:
						addr_r <= addr_r + 13'd1;
					OP_WDATA:
						addr_r[4:0] <= addr_r[4:0] + 5'd1;
					default:
						phase_r <= phase_r;
				endcase
			end
		end
	end

	// Staging of page data and state byte
	always_ff @(posedge clk)
	begin
		if (reset || (sel_fall && !busy_r))
		begin
			touched_r  <= '0;
			wr_armed_r <= 1'b0;
			st_armed_r <= 1'b0;
		end
		else if (!selected)
		begin
			wr_armed_r <= 1'b0;
			st_armed_r <= 1'b0;
		end
		else if (rise)
		begin
			// Only a deselect right after a full byte programs
			wr_armed_r <= 1'b0;
			st_armed_r <= 1'b0;
			if (byte_done && phase_r == OP_WDATA)
			begin
				page_r[addr_r[4:0]]    <= byte_in;
				touched_r[addr_r[4:0]] <= 1'b1;
				wr_armed_r             <= !blk_prot;
			end
			if (byte_done && phase_r == OP_WSTATE && latch_r && !hw_guard)
			begin
				st_new_r   <= byte_in;
				st_armed_r <= 1'b1;
			end
		end
	end

	// Self-timed programming
	logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_r;
	logic [4:0]  prog_idx_r;
	logic        prog_state_r;
	logic        mem_we;
	logic [AW-1:0] mem_waddr;
	assign mem_we    = busy_r && !prog_state_r && touched_r[prog_idx_r] &&
		(prog_cnt_r < spi_nv_pkg::PAGE_BYTES);
	assign mem_waddr = {addr_r[AW-1:5], prog_idx_r};

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			busy_r     <= 1'b0;
			prog_cnt_r <= '0;
			prog_idx_r <= 5'd0;
		end
		else if (!busy_r && sel_rise && (wr_armed_r || st_armed_r))
		begin
			busy_r       <= 1'b1;
			prog_state_r <= st_armed_r;
			prog_cnt_r   <= '0;
			prog_idx_r   <= 5'd0;
		end
		else if (busy_r)
		begin
			// Guard pin is not looked at here, so a running write always completes
			prog_cnt_r <= prog_cnt_r + 1'b1;
			prog_idx_r <= prog_idx_r + 5'd1;
			if (prog_cnt_r == PROG_CYCLES - 1)
				busy_r <= 1'b0;
		end
	end

	// Write latch and nonvolatile guard bits
	always_ff @(posedge clk)
	begin
		if (reset)
			latch_r <= 1'b0;
		else if (busy_r && prog_cnt_r == PROG_CYCLES - 1)
			latch_r <= 1'b0;
		else if (rise && byte_done && phase_r == OP_IDLE && !busy_r)
		begin
			if (opc_m == spi_nv_pkg::OPC_SET_LATCH)
				latch_r <= 1'b1;
			else if (opc_m == spi_nv_pkg::OPC_CLR_LATCH)
				latch_r <= 1'b0;
		end
	end

	// Reset stands in for the erased state of the nonvolatile cells
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			guard_en_r <= spi_nv_pkg::GUARD_RESET;
			bg_hi_r    <= spi_nv_pkg::GUARD_RESET;
			bg_lo_r    <= spi_nv_pkg::GUARD_RESET;
		end
		else if (busy_r && prog_state_r && prog_cnt_r == PROG_CYCLES - 1)
		begin
			guard_en_r <= st_new_r[spi_nv_pkg::ST_GUARD_EN];
			bg_hi_r    <= st_new_r[spi_nv_pkg::ST_BG_HI];
			bg_lo_r    <= st_new_r[spi_nv_pkg::ST_BG_LO];
		end
	end

	// Array
	logic [7:0] mem_rdata;
	nv_byte_mem #(
		.DEPTH (spi_nv_pkg::MEM_BYTES),
		.AW    (AW)
	) u_mem (
		.clk   (clk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (page_r[prog_idx_r]),
		.raddr (addr_r),
		.rdata (mem_rdata)
	);

	// Output shifter: loads at a byte boundary, shifts on falling edges
	logic [7:0] out_r;
	logic       out_act_r;
	always_ff @(posedge clk)
	begin
		if (reset || !selected)
		begin
			out_r     <= 8'h00;
			out_act_r <= 1'b0;
			sdo       <= 1'b0;
		end
		else if (fall)
		begin
			if (bitcnt_r == 3'd0 && (phase_r == OP_READ || phase_r == OP_RSTATE))
			begin
				out_act_r <= 1'b1;
				sdo       <= (phase_r == OP_READ) ? mem_rdata[7] : state_byte[7];
				out_r     <= (phase_r == OP_READ) ? {mem_rdata[6:0], 1'b0}
					: {state_byte[6:0], 1'b0};
			end
			else
			begin
				sdo   <= out_r[7];
				out_r <= {out_r[6:0], 1'b0};
			end
		end
	end

	assign sdo_oe = selected && !paused_r && out_act_r;

	property p_float_deselect;
		@(posedge clk) disable iff (reset) sel_s[1] |-> !sdo_oe;
	endproperty
	a_float_deselect: assert property (p_float_deselect)
		else $error("output driven while deselected");

	property p_float_pause;
		@(posedge clk) disable iff (reset)
			(paused_r && selected) |-> (!sdo_oe && !rise) ##1 ($stable(shift_r) && $stable(bitcnt_r));
	endproperty
	a_float_pause: assert property (p_float_pause)
		else $error("activity while paused");

	property p_busy_all_ones;
		@(posedge clk) disable iff (reset) busy_r |-> state_byte == 8'hFF;
	endproperty
	a_busy_all_ones: assert property (p_busy_all_ones)
		else $error("state byte not all ones while busy");

	property p_idle_zero_bits;
		@(posedge clk) disable iff (reset) !busy_r |-> state_byte[6:4] == 3'b000
			&& state_byte[1] == latch_r && !state_byte[0];
	endproperty
	a_idle_zero_bits: assert property (p_idle_zero_bits)
		else $error("idle state byte wrong");

	property p_busy_ends;
		@(posedge clk) disable iff (reset)
			$rose(busy_r) ##0 (PROG_CYCLES <= 300) |-> ##[1:300] !busy_r;
	endproperty
	a_busy_ends: assert property (p_busy_ends)
		else $error("programming did not finish");

	property p_latch_after_write;
		@(posedge clk) disable iff (reset) $fell(busy_r) |-> !latch_r;
	endproperty
	a_latch_after_write: assert property (p_latch_after_write)
		else $error("latch still set after write");

	property p_guard_stuck;
		@(posedge clk) disable iff (reset)
			(guard_en_r && !guard_s[1] && !busy_r) |=> guard_en_r;
	endproperty
	a_guard_stuck: assert property (p_guard_stuck)
		else $error("guard enable cleared under pin guard");

	property p_no_prot_write;
		@(posedge clk) disable iff (reset)
			$rose(wr_armed_r) |-> $past(latch_r) && !blk_prot;
	endproperty
	a_no_prot_write: assert property (p_no_prot_write)
		else $error("protected write armed");

	property p_busy_ignores;
		@(posedge clk) disable iff (reset)
			(busy_r && byte_done && phase_r == OP_IDLE) |=> phase_r inside {OP_RSTATE, OP_IGNORE};
	endproperty
	a_busy_ignores: assert property (p_busy_ignores)
		else $error("command accepted while busy");
endmodule

// ---- sim/spi_host.sv ----
// Master model for the serial memory: drives select, clock, data, pause.
// Assumes clk at 250 MHz; each serial half period is 8 clk cycles.
`timescale 1ns/1ps
module spi_host (
	// Clock
	input  wire logic clk,
	// Serial pins
	output logic      sel_n,
	output logic      sck,
	output logic      sdi,
	output logic      pause_n,
	input  wire logic sdo,
	input  wire logic sdo_oe
);
	logic oe_paused;
	logic cpol;

	initial
	begin
		sel_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
		pause_n = 1'b1;
		oe_paused = 1'b0;
		cpol = 1'b0;
	end

	task automatic half();
		repeat (8) @(negedge clk);
	endtask

	// Mode 0 idles low, mode 3 high; only switched while deselected
	task automatic set_mode(input logic pol);
		cpol = pol;
		sck = pol;
		half();
	endtask

	// Select falls with the clock at its idle level
	task automatic start();
		sel_n = 1'b0;
		half();
	endtask

	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sck = 1'b0;
			sdi = tx[i];
			half();
			sck = 1'b1;
			// Undriven line reads back inverted, so a float is never taken for data
			rx[i] = sdo_oe ? sdo : ~sdo;
			half();
		end
	endtask

	// Data line gets the inverse so a stale bit is never mistaken for data
	task automatic stop();
		sck = cpol;
		half();
		sel_n = 1'b1;
		sdi = ~sdi;
		half();
	endtask

	// Clock keeps toggling while paused; the device must not notice
	task automatic hold_toggle();
		sck = 1'b0;
		half();
		pause_n = 1'b0;
		repeat (4)
		begin
			half();
			sck = ~sck;
			sdi = ~sdi;
		end
		oe_paused = sdo_oe;
		half();
		pause_n = 1'b1;
		half();
	endtask
endmodule

// ---- sim/test_spi_nv_core.sv ----
// Self-checking bench for the serial memory front end.
// Assumes spi_host as the master; programming time shortened to 300 clk.
`timescale 1ns/1ps
module test_spi_nv_core;
	logic       clk;
	logic       reset;
	logic       guard_pin_n;
	logic       sel_n;
	logic       sck;
	logic       sdi;
	logic       pause_n;
	logic       sdo;
	logic       sdo_oe;
	int         err_count = 0;
	int         num_checks = 0;
	logic [7:0] b0;
	logic [7:0] b1;

	spi_nv_core #(.PROG_CYCLES(300)) spi_nv_core_i (
		.clk(clk), .reset(reset), .sel_n(sel_n), .sck(sck), .sdi(sdi), .sdo(sdo),
		.sdo_oe(sdo_oe), .pause_n(pause_n), .guard_pin_n(guard_pin_n)
	);
	spi_host spi_host_i (
		.clk(clk), .sel_n(sel_n), .sck(sck), .sdi(sdi), .pause_n(pause_n),
		.sdo(sdo), .sdo_oe(sdo_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic [7:0] op);
		spi_host_i.start();
		spi_host_i.xbyte(op, b0);
		spi_host_i.stop();
	endtask

	task automatic wst(input logic [7:0] d);
		spi_host_i.start();
		spi_host_i.xbyte(8'h09, b0);
		spi_host_i.xbyte(d, b0);
		spi_host_i.stop();
	endtask

	task automatic state_raw(input logic [7:0] op);
		spi_host_i.start();
		spi_host_i.xbyte(op, b0);
		spi_host_i.xbyte(8'h00, b0);
		spi_host_i.stop();
	endtask

	task automatic state(input logic [7:0] op, input logic [7:0] exp);
		state_raw(op);
		chk(b0, exp);
		chk({7'h00, sdo_oe}, 8'h00);
	endtask

	// Bounded poll of the busy flag
	task automatic wait_ready();
		for (int i = 0; i < 8; i++)
		begin
			state_raw(8'h05);
			if (b0[0] === 1'b0)
				return;
		end
		chk(b0, 8'h00);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1,
		input int n);
		spi_host_i.start();
		spi_host_i.xbyte(8'h0A, b0);
		spi_host_i.xbyte(a[15:8], b0);
		spi_host_i.xbyte(a[7:0], b0);
		spi_host_i.xbyte(d0, b0);
		if (n > 1)
			spi_host_i.xbyte(d1, b0);
		spi_host_i.stop();
	endtask

	task automatic rd(input logic [15:0] a);
		spi_host_i.start();
		spi_host_i.xbyte(8'h0B, b0);
		spi_host_i.xbyte(a[15:8], b0);
		spi_host_i.xbyte(a[7:0], b0);
		spi_host_i.xbyte(8'h00, b0);
		spi_host_i.xbyte(8'h00, b1);
		spi_host_i.stop();
	endtask

	task automatic t_latch();
		state(8'h05, 8'h00);
		cmd(8'h0E);
		spi_host_i.set_mode(1'b1);
		state(8'h0D, 8'h02);
		spi_host_i.set_mode(1'b0);
		cmd(8'h0C);
		state(8'h05, 8'h00);
	endtask

	task automatic t_page();
		cmd(8'h06);
		wr(16'h1FFF, 8'hA5, 8'h3C, 2);
		state(8'h05, 8'hFF);
		wait_ready();
		state(8'h05, 8'h00);
		cmd(8'h06);
		wr(16'hE000, 8'h5A, 8'h00, 1);
		wait_ready();
		rd(16'h1FFF);
		chk(b0, 8'hA5);
		chk(b1, 8'h5A);
		rd(16'h1FE0);
		chk(b0, 8'h3C);
	endtask

	task automatic t_nolatch();
		wr(16'h0000, 8'h11, 8'h00, 1);
		state(8'h05, 8'h00);
		rd(16'h0000);
		chk(b0, 8'h5A);
	endtask

	task automatic t_block();
		cmd(8'h06);
		wst(8'h74);
		rd(16'h1FFF);
		chk(b0, 8'hFF);
		wait_ready();
		state(8'h05, 8'h04);
		cmd(8'h06);
		wr(16'h1FFF, 8'h77, 8'h00, 1);
		state(8'h05, 8'h06);
		wr(16'h17FF, 8'h66, 8'h00, 1);
		wait_ready();
		rd(16'h17FF);
		chk(b0, 8'h66);
		rd(16'h1FFF);
		chk(b0, 8'hA5);
	endtask

	task automatic t_pin();
		cmd(8'h06);
		wst(8'h80);
		guard_pin_n = 1'b0;
		wait_ready();
		state(8'h05, 8'h80);
		cmd(8'h06);
		wst(8'h00);
		state(8'h05, 8'h82);
		cmd(8'h04);
		state(8'h05, 8'h80);
		guard_pin_n = 1'b1;
		cmd(8'h06);
		wst(8'h00);
		wait_ready();
		state(8'h05, 8'h00);
	endtask

	task automatic t_pause();
		cmd(8'h06);
		spi_host_i.start();
		spi_host_i.xbyte(8'h05, b0);
		spi_host_i.xbyte(8'h00, b0);
		spi_host_i.hold_toggle();
		chk({7'h00, spi_host_i.oe_paused}, 8'h00);
		spi_host_i.xbyte(8'h00, b1);
		spi_host_i.stop();
		chk(b0, 8'h02);
		chk(b1, 8'h02);
	endtask

	initial
	begin
		reset = 1'b1;
		guard_pin_n = 1'b1;
		repeat (6) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		t_latch();
		t_page();
		t_nolatch();
		t_block();
		t_pin();
		t_pause();
		end_sim();
	end

	// Whole run needs about 16000 cycles; nearly four times that means a hang
	initial
	begin
		repeat (60000) @(posedge clk);
		err_count++;
		end_sim();
	end
endmodule
